// *** verilog/nvram_host_pkg.sv ***
package nvram_host_pkg;

   // ****************************************
   // geometry
   // ****************************************
   localparam int ADDR_W = 21;
   localparam int DATA_W = 8;
   localparam int DEPTH = 2097152;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLOCK_HZ = 25000000;
   localparam int STARTUP_US = 2000;
   localparam int STARTUP_CYCLES = (CLOCK_HZ / 1000000) * STARTUP_US;
   localparam int ACCESS_NS = 35;
   localparam int CLOCK_NS = 40;
   // strobe low cycles, at least one, rounds up
   localparam int STROBE_CYCLES = (ACCESS_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int CNT_W = 17;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [ADDR_W-1:0] ADDR_RST = 21'h000000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   typedef enum logic [2:0] {
      ST_STARTUP = 3'b000,
      ST_IDLE    = 3'b001,
      ST_SETUP   = 3'b011,
      ST_STROBE  = 3'b111,
      ST_END     = 3'b101
   } phase_e;

   // pins toward the memory
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic select_n;
      logic write_n;
      logic drive_n;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe_n;
   } mem_pins_s;

   // user request
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } req_s;

   typedef struct packed {
      phase_e phase;
      logic [CNT_W-1:0] count;
      logic write;
      mem_pins_s pins;
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic ready;
   } host_state_s;

endpackage

// *** verilog/nvram_host.sv ***
`timescale 1ns/1ps
// Summary of operation
// - select, strobe, drive levels set mode
// - no access for 2 ms after power
// - select and strobe high during startup
// - reset holds controls high past startup
// - brownout restarts the full startup wait
// - write strobe high throughout every read
// - address valid before select falls
module nvram_host (
   input wire logic clock,
   input wire logic resetn,
   input wire logic supply_low,
   input wire nvram_host_pkg::req_s req,
   output logic req_ready,
   output logic [nvram_host_pkg::DATA_W-1:0] rdata,
   output logic rvalid,
   output logic startup_done,
   output nvram_host_pkg::mem_pins_s pins,
   input wire logic [nvram_host_pkg::DATA_W-1:0] dq_in
);

   // ****************************************
   // reset release
   // ****************************************
   logic rst_meta_ff;
   logic rst_sync_ff;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ****************************************
   // sequencer
   // ****************************************
   nvram_host_pkg::host_state_s state_ff;
   nvram_host_pkg::host_state_s nxt_state;

   // ****************************************
   // cycle limits
   // ****************************************
   localparam logic [nvram_host_pkg::CNT_W-1:0] STARTUP_LAST =
      nvram_host_pkg::CNT_W'(nvram_host_pkg::STARTUP_CYCLES - 1);
   localparam logic [nvram_host_pkg::CNT_W-1:0] STROBE_LAST =
      nvram_host_pkg::CNT_W'(nvram_host_pkg::STROBE_CYCLES - 1);

   always_comb begin
      nxt_state = state_ff;
      nxt_state.rvalid = 1'b0;
      case (state_ff.phase)
         nvram_host_pkg::ST_STARTUP: begin
            // controls parked high, bus released
            nxt_state.pins.select_n = 1'b1;
            nxt_state.pins.write_n = 1'b1;
            nxt_state.pins.drive_n = 1'b1;
            nxt_state.pins.dq_oe_n = 1'b1;
            if (state_ff.count == STARTUP_LAST) begin
               nxt_state.phase = nvram_host_pkg::ST_IDLE;
               nxt_state.ready = 1'b1;
            end else begin
               nxt_state.count = state_ff.count + 1'b1;
            end
         end
         nvram_host_pkg::ST_IDLE: begin
            // controls parked between accesses
            nxt_state.pins.select_n = 1'b1;
            nxt_state.pins.write_n = 1'b1;
            nxt_state.pins.drive_n = 1'b1;
            nxt_state.pins.dq_oe_n = 1'b1;
            if (req.valid) begin
               // address first, select later
               nxt_state.pins.addr = req.addr;
               nxt_state.pins.dq_out = req.wdata;
               nxt_state.write = req.write;
               nxt_state.ready = 1'b0;
               nxt_state.phase = nvram_host_pkg::ST_SETUP;
            end
         end
         nvram_host_pkg::ST_SETUP: begin
            nxt_state.pins.select_n = 1'b0;
            nxt_state.count = '0;
            if (state_ff.write) begin
               nxt_state.pins.write_n = 1'b0;
               nxt_state.pins.drive_n = 1'b1;
               nxt_state.pins.dq_oe_n = 1'b0;
            end else begin
               nxt_state.pins.write_n = 1'b1;
               nxt_state.pins.drive_n = 1'b0;
               nxt_state.pins.dq_oe_n = 1'b1;
            end
            nxt_state.phase = nvram_host_pkg::ST_STROBE;
         end
         nvram_host_pkg::ST_STROBE: begin
            if (state_ff.count == STROBE_LAST) begin
               if (!state_ff.write) begin
                  nxt_state.rdata = dq_in;
                  nxt_state.rvalid = 1'b1;
               end
               // both controls rise together, ends write
               nxt_state.pins.select_n = 1'b1;
               nxt_state.pins.write_n = 1'b1;
               nxt_state.pins.drive_n = 1'b1;
               nxt_state.phase = nvram_host_pkg::ST_END;
            end else begin
               nxt_state.count = state_ff.count + 1'b1;
            end
         end
         nvram_host_pkg::ST_END: begin
            // data held one cycle past strobe rise
            nxt_state.pins.select_n = 1'b1;
            nxt_state.pins.write_n = 1'b1;
            nxt_state.pins.drive_n = 1'b1;
            nxt_state.pins.dq_oe_n = 1'b1;
            nxt_state.ready = 1'b1;
            nxt_state.phase = nvram_host_pkg::ST_IDLE;
         end
         default: begin
            // lost state: park and wait again
            nxt_state.phase = nvram_host_pkg::ST_STARTUP;
            nxt_state.count = '0;
            nxt_state.ready = 1'b0;
            nxt_state.pins.select_n = 1'b1;
            nxt_state.pins.write_n = 1'b1;
            nxt_state.pins.drive_n = 1'b1;
            nxt_state.pins.dq_oe_n = 1'b1;
         end
      endcase
      // low supply aborts and restarts the wait
      if (supply_low) begin
         nxt_state.phase = nvram_host_pkg::ST_STARTUP;
         nxt_state.count = '0;
         nxt_state.ready = 1'b0;
         // aborted read gives no answer
         nxt_state.rvalid = 1'b0;
         nxt_state.pins.select_n = 1'b1;
         nxt_state.pins.write_n = 1'b1;
         nxt_state.pins.drive_n = 1'b1;
         nxt_state.pins.dq_oe_n = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff.phase <= nvram_host_pkg::ST_STARTUP;
         state_ff.count <= '0;
         state_ff.write <= 1'b0;
         state_ff.pins.addr <= nvram_host_pkg::ADDR_RST;
         state_ff.pins.select_n <= 1'b1;
         state_ff.pins.write_n <= 1'b1;
         state_ff.pins.drive_n <= 1'b1;
         state_ff.pins.dq_out <= nvram_host_pkg::DATA_RST;
         state_ff.pins.dq_oe_n <= 1'b1;
         state_ff.rdata <= nvram_host_pkg::DATA_RST;
         state_ff.rvalid <= 1'b0;
         state_ff.ready <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign pins = state_ff.pins;
   assign rdata = state_ff.rdata;
   assign rvalid = state_ff.rvalid;
   assign req_ready = state_ff.ready;
   assign startup_done = state_ff.phase != nvram_host_pkg::ST_STARTUP;

endmodule

// *** sim/nvram_model.sv ***
`timescale 1ns/1ps
module nvram_model (
   input wire logic supply_low,
   input wire nvram_host_pkg::mem_pins_s pins,
   output logic [7:0] dq_in
);
   bit [7:0] mem [nvram_host_pkg::DEPTH];
   logic [7:0] last = 8'h00;
   wire rd = !pins.select_n && pins.write_n && !pins.drive_n;
   wire wr = !pins.select_n && !pins.write_n;
   // commit at first control rising, lockout blocks it
   always @(negedge wr) if (!supply_low) mem[pins.addr] = pins.dq_out;
   always @(negedge rd) last = mem[pins.addr];
   // floating bus shows inverse of last byte
   always @(pins or last) begin
      if (!pins.dq_oe_n) dq_in = pins.dq_out;
      else if (rd) dq_in = mem[pins.addr];
      else dq_in = ~last;
   end
endmodule

// *** sim/nvram_host_checker.sv ***
`timescale 1ns/1ps
module nvram_host_checker (
   input wire logic clock,
   input wire logic resetn,
   input wire logic supply_low,
   input wire nvram_host_pkg::req_s req,
   input wire logic req_ready,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic startup_done,
   input wire nvram_host_pkg::mem_pins_s pins,
   input wire logic [7:0] dq_in
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   sequence take(w); req.valid && req_ready && req.write == w; endsequence
   sequence parked; pins.select_n && pins.write_n; endsequence
   a_quiet_startup: assert property (!startup_done |-> parked)
      else $error("control low in startup");
   a_ready_late: assert property (req_ready |-> startup_done)
      else $error("ready before startup");
   a_brownout_park: assert property (
      supply_low |=> parked ##0 !startup_done) else $error("no park");
   a_write_cycle: assert property (
      disable iff (!resetn || supply_low) take(1'h1) |-> ##2
      (!pins.select_n && !pins.write_n && !pins.dq_oe_n) ##1
      (parked ##0 !pins.dq_oe_n) ##1 (pins.dq_oe_n && req_ready))
      else $error("bad write cycle");
   a_read_cycle: assert property (
      disable iff (!resetn || supply_low) take(1'h0) |-> ##2
      (!pins.select_n && !pins.drive_n && pins.dq_oe_n) ##1
      (rvalid && rdata == $past(dq_in))) else $error("bad read cycle");
   a_read_strobe: assert property (!pins.drive_n |-> pins.write_n)
      else $error("strobe low in read");
   a_addr_first: assert property (
      $fell(pins.select_n) |-> $stable(pins.addr)) else $error("late addr");
   a_bus_free: assert property (!pins.dq_oe_n |-> pins.drive_n)
      else $error("bus contention");
   a_abort_quiet: assert property (supply_low |=> !rvalid)
      else $error("answer after abort");
endmodule
bind nvram_host nvram_host_checker i_chk (.*);

// *** sim/tb_async_nonvolatile_byte_memory_port.sv ***
`timescale 1ns/1ps
module tb_async_nonvolatile_byte_memory_port;
   typedef struct packed {logic w; logic [20:0] a; logic [7:0] d;} row_s;
   logic clock = 1'h0, resetn = 1'h0, supply_low = 1'h0;
   logic req_ready, rvalid, startup_done;
   logic [7:0] rdata, dq_in;
   nvram_host_pkg::req_s req = '0;
   nvram_host_pkg::mem_pins_s pins;
   int error_cnt = 0, check_count = 0, cyc = 0;
   row_s rows [4] = '{'{1'h1, 21'h000000, 8'h5a}, '{1'h1, 21'h1fffff, 8'ha5},
      '{1'h0, 21'h000000, 8'h5a}, '{1'h0, 21'h1fffff, 8'ha5}};
   always #20 clock = ~clock;
   nvram_host i_dut (.*);
   nvram_model i_mem (.*);
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t %h %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock) if (++cyc == 100500) begin
      error_cnt++;
      final_report;
   end
   task access(input row_s r);
      req = '{1'h1, r.w, r.a, r.d};
      @(negedge clock);
      while (req_ready !== 1'h1) @(negedge clock);
      @(posedge clock) #1 req.valid = 1'h0;
      if (!r.w) begin
         while (rvalid !== 1'h1) @(negedge clock);
         check(rdata, r.d);
      end
      @(posedge clock) #1;
   endtask
   task startup_wait;
      int n;
      n = 0;
      while (req_ready !== 1'h1) @(posedge clock) #1 n++;
      check(8'(n >= 50000 && n <= 50008), 8'h01);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      #1 check({6'h0, pins.select_n, pins.write_n}, 8'h03);
      $display("reset test done");
      resetn = 1'h1;
      startup_wait;
      $display("startup test done");
      foreach (rows[i]) access(rows[i]);
      $display("table test done");
      access('{1'h1, 21'h000000, 8'hff});
      // brownout lands before the write ends
      supply_low = 1'h1;
      repeat (3) @(posedge clock);
      #1 check({7'h0, startup_done}, 8'h00);
      supply_low = 1'h0;
      startup_wait;
      access('{1'h0, 21'h000000, 8'h5a});
      $display("brownout test done");
      final_report;
   end
endmodule
